/* hdl/mdu_pkg.sv */
// Purpose: shared constants and types of the multiply/divide unit and its controller
// Assumes: 16-bit core words, one clock, active-low asynchronous reset
// Notes: the controller offsets are byte addresses of aligned 32-bit words
package mdu_pkg;
	typedef enum logic [2:0] {
		MDU_UMUL, MDU_MUL, MDU_DIVU, MDU_DIV, MDU_DIVLU, MDU_DIVL
	} mdu_op_t;
	typedef enum logic [1:0] {MDU_SEL_LOW, MDU_SEL_HIGH, MDU_SEL_CTRL} mdu_sel_t;
	// control register layout
	localparam int MDC_STEP_LSB = 0;
	localparam int MDC_STEP_W   = 4;
	localparam int MDC_RIU_BIT  = 4;
	localparam int MDC_NEGQ_BIT = 5;
	localparam int MDC_NEGR_BIT = 6;
	localparam int MDC_OVF_BIT  = 7;
	localparam int MDC_ACT_BIT  = 8;
	localparam logic [15:0] MDC_RESET = 16'h0000;
	localparam logic [3:0]  MDU_LAST_STEP = 4'hF;
	// status word
	localparam int PSW_V_BIT     = 2;
	localparam int PSW_INPROG_BIT = 7;
	localparam logic [15:0] PSW_RESET = 16'h0000;
	// controller registers
	localparam logic [7:0] HR_CMD    = 8'h00;
	localparam logic [7:0] HR_OPA    = 8'h04;
	localparam logic [7:0] HR_OPB    = 8'h08;
	localparam logic [7:0] HR_RESULT = 8'h0C;
	localparam logic [7:0] HR_STATUS = 8'h10;
	localparam logic [7:0] HR_ISTAT  = 8'h14;
	localparam logic [7:0] HR_IMASK  = 8'h18;
	localparam logic [7:0] HR_SAVE   = 8'h1C;
	localparam logic [7:0] HR_TASK   = 8'h20;
	localparam int CMD_OP_LSB    = 0;
	localparam int CMD_START_BIT = 4;
	localparam int CMD_IRQ_BIT   = 5;
	localparam int CMD_RETURN_FROM_INTERRUPT_BIT  = 6;
	localparam int CMD_ADDR_LSB  = 16;
	localparam int EV_DONE    = 0;
	localparam int EV_OVF     = 1;
	localparam int EV_INTR    = 2;
	localparam int EV_REFETCH = 3;
	localparam int EV_W       = 4;
endpackage

/* hdl/mdu_if.sv */
// Purpose: link between the pipeline-side controller and the multiply/divide unit
// Assumes: both ends on pclk
// Notes: pulses last one cycle; read data is valid the cycle after a read strobe
`timescale 1ns/1ns
interface mdu_if;
	logic              op_valid;
	mdu_pkg::mdu_op_t  op_code;
	logic [15:0]       op_a;
	logic [15:0]       op_b;
	logic [15:0]       op_addr;
	logic              op_done;
	logic              busy;
	logic              reg_wr;
	logic              reg_rd;
	mdu_pkg::mdu_sel_t reg_sel;
	logic [15:0]       reg_wdata;
	logic [15:0]       reg_rdata;
	logic              psw_wr;
	logic [15:0]       psw_wdata;
	logic [15:0]       processor_status_word;
	logic              irq_take;
	logic [15:0]       irq_addr;
	logic              irq_ack;
	logic [15:0]       ret_addr;
	logic              return_from_interrupt;
	logic [15:0]       return_from_interrupt_psw;
	logic              refetch;
	modport dev (input op_valid, op_code, op_a, op_b, op_addr, reg_wr, reg_rd, reg_sel,
		reg_wdata, psw_wr, psw_wdata, irq_take, irq_addr, return_from_interrupt, return_from_interrupt_psw,
		output op_done, busy, reg_rdata, processor_status_word, irq_ack, ret_addr, refetch);
	modport host (output op_valid, op_code, op_a, op_b, op_addr, reg_wr, reg_rd, reg_sel,
		reg_wdata, psw_wr, psw_wdata, irq_take, irq_addr, return_from_interrupt, return_from_interrupt_psw,
		input op_done, busy, reg_rdata, processor_status_word, irq_ack, ret_addr, refetch);
endinterface

/* hdl/mdu_unit.sv */
// Purpose: sequential multiply/divide datapath with resumable state
// Assumes: partner keeps to the save/clear/restore protocol of the control register
// Notes: magnitudes are processed, signs applied in a final fix-up cycle
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
module mdu_unit (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	mdu_if.dev        bus,
	output logic      busy,
	output logic      result_in_use
);
	typedef enum logic [1:0] {MDU_ST_IDLE, MDU_ST_RUN, MDU_ST_FIX} mdu_state_t;

	mdu_state_t       st;
	mdu_pkg::mdu_op_t op_q;
	logic [31:0]      acc;
	logic [15:0]      mdc;
	logic [15:0]      opnd;
	logic [15:0]      processor_status_word;
	logic [15:0]      cur_addr;
	logic             start;
	logic             resume;
	logic             take_mid;
	logic             wr_ok;
	logic [31:0]      dvd;
	logic [31:0]      dvd_mag;
	logic [15:0]      a_mag;
	logic             in_sgn;
	logic [16:0]      msum;
	logic [16:0]      dhi;
	logic [16:0]      ddif;
	logic [31:0]      acc_step;
	logic [31:0]      fix_res;
	logic             fix_ovf;

	function automatic logic op_div(input mdu_pkg::mdu_op_t o);
		op_div = (o == mdu_pkg::MDU_DIVU) || (o == mdu_pkg::MDU_DIV) ||
			(o == mdu_pkg::MDU_DIVLU) || (o == mdu_pkg::MDU_DIVL);
	endfunction

	function automatic logic op_sgn(input mdu_pkg::mdu_op_t o);
		op_sgn = (o == mdu_pkg::MDU_MUL) || (o == mdu_pkg::MDU_DIV) ||
			(o == mdu_pkg::MDU_DIVL);
	endfunction

	function automatic logic [15:0] neg16(input logic [15:0] x, input logic n);
		neg16 = n ? 16'(~x + 16'h0001) : x;
	endfunction

	function automatic logic [31:0] neg32(input logic [31:0] x, input logic n);
		neg32 = n ? 32'(~x + 32'h00000001) : x;
	endfunction

	// request decode; a resume is a start with live state in the control register
	assign start    = bus.op_valid && (st == MDU_ST_IDLE);
	assign resume   = mdc[mdu_pkg::MDC_ACT_BIT];
	assign take_mid = bus.irq_take && (st == MDU_ST_RUN);
	assign wr_ok    = bus.reg_wr && (st == MDU_ST_IDLE);
	assign in_sgn   = op_sgn(bus.op_code);
	assign a_mag    = neg16(bus.op_a, in_sgn && bus.op_a[15]);

	// dividend selection: short forms ignore the high half
	always_comb begin
		if (bus.op_code == mdu_pkg::MDU_DIVLU || bus.op_code == mdu_pkg::MDU_DIVL)
			dvd = acc;
		else if (in_sgn)
			dvd = {{16{acc[15]}}, acc[15:0]};
		else
			dvd = {16'h0000, acc[15:0]};
		dvd_mag = neg32(dvd, in_sgn && dvd[31]);
	end

	// one shift-add or shift-subtract step per cycle
	assign msum = {1'b0, acc[31:16]} + (acc[0] ? {1'b0, opnd} : 17'h00000);
	assign dhi  = acc[31:15];
	assign ddif = dhi - {1'b0, opnd};
	always_comb begin
		if (!op_div(op_q))
			acc_step = {msum, acc[15:1]};
		else if (dhi >= {1'b0, opnd})
			acc_step = {ddif[15:0], acc[14:0], 1'b1};
		else
			acc_step = {acc[30:0], 1'b0};
	end

	// sign fix-up and range check of the finished result
	always_comb begin
		if (!op_div(op_q)) begin
			fix_res = neg32(acc, mdc[mdu_pkg::MDC_NEGQ_BIT]);
			if (op_sgn(op_q))
				fix_ovf = fix_res[31:16] != {16{fix_res[15]}};
			else
				fix_ovf = |fix_res[31:16];
		end else begin
			fix_res = {neg16(acc[31:16], mdc[mdu_pkg::MDC_NEGR_BIT]),
				neg16(acc[15:0], mdc[mdu_pkg::MDC_NEGQ_BIT])};
			// signed quotient may reach 8000 only when negative
			fix_ovf = mdc[mdu_pkg::MDC_OVF_BIT] || (op_sgn(op_q) &&
				(mdc[mdu_pkg::MDC_NEGQ_BIT] ? (acc[15:0] > 16'h8000) : acc[15]));
		end
	end

	// sequencer: several cycles per operation, abandoned on a mid-run interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= MDU_ST_IDLE;
		end else if (ce) begin
			unique case (st)
				MDU_ST_IDLE: if (start) st <= MDU_ST_RUN;
				MDU_ST_RUN: begin
					if (take_mid)
						st <= MDU_ST_IDLE;
					else if (mdc[3:0] == mdu_pkg::MDU_LAST_STEP)
						st <= MDU_ST_FIX;
				end
				MDU_ST_FIX: st <= MDU_ST_IDLE;
			endcase
		end
	end

	// operation latch; the operand is re-supplied by the refetched instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q     <= mdu_pkg::MDU_UMUL;
			opnd     <= 16'h0000;
			cur_addr <= 16'h0000;
		end else if (ce && start) begin
			op_q     <= bus.op_code;
			opnd     <= a_mag;
			cur_addr <= bus.op_addr;
		end
	end

	// result register, one 32-bit value in two halves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 32'h00000000;
		end else if (ce) begin
			if (wr_ok && bus.reg_sel == mdu_pkg::MDU_SEL_LOW)
				acc[15:0] <= bus.reg_wdata;
			if (wr_ok && bus.reg_sel == mdu_pkg::MDU_SEL_HIGH)
				acc[31:16] <= bus.reg_wdata;
			if (start && !resume) begin
				if (op_div(bus.op_code))
					acc <= dvd_mag;
				else
					acc <= {16'h0000, neg16(bus.op_b, in_sgn && bus.op_b[15])};
			end
			if (st == MDU_ST_RUN && !take_mid)
				acc <= acc_step;
			if (st == MDU_ST_FIX)
				acc <= fix_res;
		end
	end

	// control register: step count and signs live here, so an abort leaves resume state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc <= mdu_pkg::MDC_RESET;
		end else if (ce) begin
			if (bus.reg_rd && bus.reg_sel == mdu_pkg::MDU_SEL_LOW)
				mdc[mdu_pkg::MDC_RIU_BIT] <= 1'b0;
			if (wr_ok && bus.reg_sel == mdu_pkg::MDU_SEL_CTRL)
				mdc <= bus.reg_wdata;
			// set after clear so a simultaneous write or start wins
			if (wr_ok && bus.reg_sel != mdu_pkg::MDU_SEL_CTRL)
				mdc[mdu_pkg::MDC_RIU_BIT] <= 1'b1;
			if (start) begin
				mdc[mdu_pkg::MDC_RIU_BIT] <= 1'b1;
				mdc[mdu_pkg::MDC_ACT_BIT] <= 1'b1;
				if (!resume) begin
					mdc[3:0] <= 4'h0;
					if (op_div(bus.op_code)) begin
						mdc[mdu_pkg::MDC_NEGR_BIT] <= in_sgn && dvd[31];
						mdc[mdu_pkg::MDC_NEGQ_BIT] <= in_sgn && (dvd[31] ^ bus.op_a[15]);
						mdc[mdu_pkg::MDC_OVF_BIT]  <= (bus.op_a == 16'h0000) ||
							(dvd_mag[31:16] >= a_mag);
					end else begin
						mdc[mdu_pkg::MDC_NEGR_BIT] <= 1'b0;
						mdc[mdu_pkg::MDC_NEGQ_BIT] <= in_sgn && (bus.op_a[15] ^ bus.op_b[15]);
						mdc[mdu_pkg::MDC_OVF_BIT]  <= 1'b0;
					end
				end
			end
			if (st == MDU_ST_RUN && !take_mid)
				mdc[3:0] <= 4'(mdc[3:0] + 4'h1);
			if (st == MDU_ST_FIX) begin
				mdc[3:0] <= 4'h0;
				mdc[8:5] <= 4'h0;
			end
		end
	end

	// status word: software writes, return restores, hardware sets win last
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			processor_status_word <= mdu_pkg::PSW_RESET;
		end else if (ce) begin
			if (bus.psw_wr)
				processor_status_word <= bus.psw_wdata;
			if (bus.return_from_interrupt)
				processor_status_word <= bus.return_from_interrupt_psw;
			if (take_mid)
				processor_status_word[mdu_pkg::PSW_INPROG_BIT] <= 1'b1;
			if (st == MDU_ST_FIX)
				processor_status_word[mdu_pkg::PSW_V_BIT] <= fix_ovf;
		end
	end

	// interrupt and return answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.irq_ack  <= 1'b0;
			bus.ret_addr <= 16'h0000;
			bus.refetch  <= 1'b0;
			bus.op_done  <= 1'b0;
		end else if (ce) begin
			bus.irq_ack <= bus.irq_take;
			if (bus.irq_take)
				bus.ret_addr <= take_mid ? cur_addr : bus.irq_addr;
			// old flag is sampled before the popped word lands
			bus.refetch <= bus.return_from_interrupt && processor_status_word[mdu_pkg::PSW_INPROG_BIT];
			bus.op_done <= (st == MDU_ST_FIX);
		end
	end

	// register read port, data one cycle after the strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.reg_rdata <= 16'h0000;
		end else if (ce && bus.reg_rd) begin
			unique case (bus.reg_sel)
				mdu_pkg::MDU_SEL_LOW:  bus.reg_rdata <= acc[15:0];
				mdu_pkg::MDU_SEL_HIGH: bus.reg_rdata <= acc[31:16];
				mdu_pkg::MDU_SEL_CTRL: bus.reg_rdata <= mdc;
				default:               bus.reg_rdata <= 16'h0000;
			endcase
		end
	end

	assign bus.processor_status_word       = processor_status_word;
	assign bus.busy      = (st != MDU_ST_IDLE);
	assign busy          = bus.busy;
	assign result_in_use = mdc[mdu_pkg::MDC_RIU_BIT];
endmodule // mdu_unit

/* hdl/mdu_host.sv */
// Purpose: pipeline-side controller of the multiply/divide unit, driven over APB
// Assumes: zero-wait APB slave, prdata prepared in the setup cycle
// Notes: an interrupt command arriving with op_done in the same cycle is dropped
`timescale 1ns/1ns
module mdu_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	mdu_if.host              bus
);
	typedef enum logic [3:0] {
		H_IDLE, H_CLR, H_ISSUE, H_WAIT, H_RDH, H_RDL, H_CAP,
		H_IRQ, H_IACK, H_RDC, H_CAPC, H_WRC, H_RETURN_FROM_INTERRUPT, H_RWT
	} mdu_hstate_t;

	mdu_hstate_t           st;
	mdu_pkg::mdu_op_t      op_q;
	logic [15:0]           addr_q;
	logic [15:0]           opa;
	logic [15:0]           opb;
	logic [31:0]           res;
	logic [mdu_pkg::EV_W-1:0] istat;
	logic [mdu_pkg::EV_W-1:0] imask;
	logic [mdu_pkg::EV_W-1:0] ev;
	logic [15:0]           saved_mdc;
	logic [15:0]           saved_psw;
	logic [15:0]           ret_q;
	logic                  task_inprog;
	logic                  wr;
	logic                  mapped;
	logic                  cmd_wr;
	logic [15:0]           psw_task;

	assign wr     = psel && penable && pwrite;
	assign cmd_wr = wr && paddr == mdu_pkg::HR_CMD;
	assign mapped = paddr inside {mdu_pkg::HR_CMD, mdu_pkg::HR_OPA, mdu_pkg::HR_OPB,
		mdu_pkg::HR_RESULT, mdu_pkg::HR_STATUS, mdu_pkg::HR_ISTAT, mdu_pkg::HR_IMASK,
		mdu_pkg::HR_SAVE, mdu_pkg::HR_TASK};
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// sequence: clear, issue, wait, read high then low; interrupt and return paths
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= H_IDLE;
		end else if (ce) begin
			unique case (st)
				H_IDLE: begin
					if (cmd_wr && pwdata[mdu_pkg::CMD_START_BIT])
						st <= H_CLR;
					else if (cmd_wr && pwdata[mdu_pkg::CMD_IRQ_BIT])
						st <= H_IRQ;
					else if (cmd_wr && pwdata[mdu_pkg::CMD_RETURN_FROM_INTERRUPT_BIT])
						st <= H_WRC;
				end
				H_CLR:   st <= H_ISSUE;
				H_ISSUE: st <= H_WAIT;
				H_WAIT: begin
					if (bus.op_done)
						st <= H_RDH;
					else if (cmd_wr && pwdata[mdu_pkg::CMD_IRQ_BIT])
						st <= H_IRQ;
				end
				H_RDH:  st <= H_RDL;
				H_RDL:  st <= H_CAP;
				H_CAP:  st <= H_IDLE;
				H_IRQ:  st <= H_IACK;
				H_IACK: if (bus.irq_ack) st <= H_RDC;
				H_RDC:  st <= H_CAPC;
				H_CAPC: st <= H_IDLE;
				H_WRC:  st <= H_RETURN_FROM_INTERRUPT;
				H_RETURN_FROM_INTERRUPT: st <= H_RWT;
				H_RWT:  st <= bus.refetch ? H_ISSUE : H_IDLE;
			endcase
		end
	end

	// captured data from the unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res        <= 32'h00000000;
			saved_mdc  <= 16'h0000;
			saved_psw  <= 16'h0000;
			ret_q      <= 16'h0000;
			task_inprog <= 1'b0;
		end else if (ce) begin
			if (st == H_RDL)
				res[31:16] <= bus.reg_rdata;
			if (st == H_CAP)
				res[15:0] <= bus.reg_rdata;
			if (st == H_IRQ)
				saved_psw <= bus.processor_status_word;
			if (st == H_IACK && bus.irq_ack)
				ret_q <= bus.ret_addr;
			if (st == H_CAPC) begin
				saved_mdc  <= bus.reg_rdata;
				task_inprog <= bus.processor_status_word[mdu_pkg::PSW_INPROG_BIT];
			end
			if (wr && paddr == mdu_pkg::HR_TASK)
				task_inprog <= pwdata[0];
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q   <= mdu_pkg::MDU_UMUL;
			addr_q <= 16'h0000;
			opa    <= 16'h0000;
			opb    <= 16'h0000;
			imask  <= '0;
		end else if (ce) begin
			// the operation survives interrupt and return commands, so a refetch repeats it
			if (cmd_wr && pwdata[mdu_pkg::CMD_START_BIT] && st == H_IDLE)
				op_q <= mdu_pkg::mdu_op_t'(pwdata[mdu_pkg::CMD_OP_LSB +: 3]);
			if (cmd_wr)
				addr_q <= pwdata[mdu_pkg::CMD_ADDR_LSB +: 16];
			if (st == H_RWT && bus.refetch)
				addr_q <= ret_q;
			if (wr && paddr == mdu_pkg::HR_OPA)
				opa <= pwdata[15:0];
			if (wr && paddr == mdu_pkg::HR_OPB)
				opb <= pwdata[15:0];
			if (wr && paddr == mdu_pkg::HR_IMASK)
				imask <= pwdata[mdu_pkg::EV_W-1:0];
		end
	end

	// sticky events, write one to clear; a new event in the same cycle survives
	always_comb begin
		ev = '0;
		ev[mdu_pkg::EV_DONE]    = (st == H_CAP);
		ev[mdu_pkg::EV_OVF]     = (st == H_CAP) && bus.processor_status_word[mdu_pkg::PSW_V_BIT];
		ev[mdu_pkg::EV_INTR]    = bus.irq_ack;
		ev[mdu_pkg::EV_REFETCH] = bus.refetch;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			istat <= '0;
		else if (ce)
			istat <= (istat & ~((wr && paddr == mdu_pkg::HR_ISTAT) ?
				pwdata[mdu_pkg::EV_W-1:0] : '0)) | ev;
	end
	assign irq = |(istat & imask);

	// read data prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable) begin
			unique case (paddr)
				mdu_pkg::HR_CMD:    prdata <= {addr_q, 13'h0000, op_q};
				mdu_pkg::HR_OPA:    prdata <= {16'h0000, opa};
				mdu_pkg::HR_OPB:    prdata <= {16'h0000, opb};
				mdu_pkg::HR_RESULT: prdata <= res;
				mdu_pkg::HR_STATUS: prdata <= {bus.processor_status_word, 14'h0000, bus.busy, st != H_IDLE};
				mdu_pkg::HR_ISTAT:  prdata <= {28'h0000000, istat};
				mdu_pkg::HR_IMASK:  prdata <= {28'h0000000, imask};
				mdu_pkg::HR_SAVE:   prdata <= {saved_mdc, ret_q};
				mdu_pkg::HR_TASK:   prdata <= {31'h00000000, task_inprog};
				default:            prdata <= 32'h00000000;
			endcase
		end
	end

	// strobes to the unit follow the state
	always_comb begin
		psw_task = bus.processor_status_word;
		psw_task[mdu_pkg::PSW_INPROG_BIT] = task_inprog;
	end
	assign bus.op_valid  = (st == H_ISSUE);
	assign bus.op_code   = op_q;
	assign bus.op_a      = opa;
	assign bus.op_b      = opb;
	assign bus.op_addr   = addr_q;
	assign bus.reg_wr    = (st == H_CLR) || (st == H_WRC);
	assign bus.reg_rd    = (st == H_RDH) || (st == H_RDL) || (st == H_RDC);
	assign bus.reg_sel   = (st == H_RDH) ? mdu_pkg::MDU_SEL_HIGH :
		(st == H_RDL) ? mdu_pkg::MDU_SEL_LOW : mdu_pkg::MDU_SEL_CTRL;
	assign bus.reg_wdata = (st == H_WRC) ? saved_mdc : 16'h0000;
	assign bus.psw_wr    = (st == H_WRC);
	assign bus.psw_wdata = psw_task;
	assign bus.irq_take  = (st == H_IRQ);
	assign bus.irq_addr  = addr_q;
	assign bus.return_from_interrupt      = (st == H_RETURN_FROM_INTERRUPT);
	assign bus.return_from_interrupt_psw  = saved_psw;
endmodule // mdu_host

/* sim/mdu_checker.sv */
// Purpose: timing assertions on the link between controller and multiply/divide unit
// Assumes: one clock, ce held high, fresh starts follow a clear of the control register
// Notes: resumed operations finish early, so only fresh starts get the exact latency
`timescale 1ns/1ns
module mdu_checker (
	input logic              pclk,
	input logic              presetn,
	input logic              op_valid,
	input logic [15:0]       op_addr,
	input logic              op_done,
	input logic              busy,
	input logic              reg_wr,
	input mdu_pkg::mdu_sel_t reg_sel,
	input logic [15:0]       reg_wdata,
	input logic [15:0]       processor_status_word,
	input logic              irq_take,
	input logic [15:0]       irq_addr,
	input logic              irq_ack,
	input logic [15:0]       ret_addr,
	input logic              return_from_interrupt,
	input logic [15:0]       return_from_interrupt_psw,
	input logic              refetch
);
	logic        clr_q;
	logic        irq_hit;
	logic [15:0] addr_q;
	// irq_hit excuses a missing done; only a fresh start clears it, not a resume
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_q   <= 1'b0;
			irq_hit <= 1'b0;
			addr_q  <= 16'h0000;
		end else begin
			clr_q <= reg_wr && reg_sel == mdu_pkg::MDU_SEL_CTRL && reg_wdata == 16'h0000;
			if (op_valid && !busy)
				addr_q <= op_addr;
			if (irq_take)
				irq_hit <= 1'b1;
			else if (op_valid && !busy && clr_q)
				irq_hit <= 1'b0;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_start;
		op_valid && !busy;
	endsequence
	sequence s_run_irq;
		irq_take && busy ##1 !op_done;
	endsequence
	start_busy_a: assert property (s_start |=> busy)
		else $error("busy not raised after start");
	done_lat_a: assert property (op_valid && !busy && clr_q |->
		##18 (op_done || irq_hit))
		else $error("done not 18 cycles after fresh start");
	done_idle_a: assert property (op_done |-> !busy && $past(busy, 2))
		else $error("done without a preceding run");
	ack_lat_a: assert property (irq_take |=> irq_ack)
		else $error("interrupt not acknowledged");
	ret_run_a: assert property (s_run_irq |-> ret_addr == addr_q)
		else $error("return address not the running operation");
	ret_idle_a: assert property (irq_take && !busy |=> ret_addr == $past(irq_addr))
		else $error("return address not the interrupt address");
	inprog_set_a: assert property (s_run_irq |-> processor_status_word[mdu_pkg::PSW_INPROG_BIT])
		else $error("in-progress flag not set");
	abort_run_a: assert property (s_run_irq |-> (!op_done)[*8])
		else $error("interrupted operation still finished");
	refetch_a: assert property (return_from_interrupt |=>
		refetch == $past(processor_status_word[mdu_pkg::PSW_INPROG_BIT]))
		else $error("refetch does not follow the in-progress flag");
	return_from_interrupt_psw_a: assert property (return_from_interrupt && !busy && !irq_take |=> processor_status_word == $past(return_from_interrupt_psw))
		else $error("status word not restored on return");
endmodule // mdu_checker

/* sim/testbench.sv */
// Purpose: self-checking bench of controller and unit joined by their link
// Assumes: zero-wait APB, the controller clears the control register before each fresh start
// Notes: a division takes its dividend from the previous product, so each follows a multiply
`timescale 1ns/1ns
module testbench;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, ubusy, riu, re;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv, acc;
	logic [32:0] e;
	int          bad_count, total_checks, cop;
	int          cyc = 0;
	mdu_if bus ();
	mdu_unit u_mdu_unit (.pclk(pclk), .presetn(presetn), .ce(ce), .bus(bus), .busy(ubusy),
		.result_in_use(riu));
	mdu_host u_mdu_host (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .bus(bus));
	mdu_checker u_mdu_checker (.pclk(pclk), .presetn(presetn), .op_valid(bus.op_valid),
		.op_addr(bus.op_addr), .op_done(bus.op_done), .busy(bus.busy), .reg_wr(bus.reg_wr),
		.reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata), .processor_status_word(bus.processor_status_word), .irq_take(bus.irq_take),
		.irq_addr(bus.irq_addr), .irq_ack(bus.irq_ack), .ret_addr(bus.ret_addr), .return_from_interrupt(bus.return_from_interrupt),
		.return_from_interrupt_psw(bus.return_from_interrupt_psw), .refetch(bus.refetch));
	// 125 MHz
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		total_checks++;
		if (x !== s) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	// one APB transfer; read data and error taken at the edge that sees pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// reference result {overflow, high, low}; truncating division, remainder takes dividend sign
	function automatic logic [32:0] model(input int op, input logic [31:0] m,
		input logic [15:0] a, input logic [15:0] b);
		longint x, y, q;
		logic   sg;
		sg = op % 2 == 1;
		if (op < 2) begin
			x = sg ? longint'($signed(a)) * longint'($signed(b)) : longint'(a) * longint'(b);
			return {sg ? (x < -32768 || x > 32767) : x > 65535, x[31:0]};
		end
		if (op > 3)
			y = sg ? longint'($signed(m)) : longint'(m);
		else
			y = sg ? longint'($signed(m[15:0])) : longint'(m[15:0]);
		x = sg ? longint'($signed(a)) : longint'(a);
		if (x == 0)
			return {1'b1, 32'h0000_0000};
		q = y / x;
		y = y % x;
		return {sg ? (q < -32768 || q > 32767) : q > 65535, y[15:0], q[15:0]};
	endfunction
	task automatic go(input int op, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] ad);
		cop = op;
		e = model(op, acc, a, b);
		apb(1'b1, mdu_pkg::HR_OPA, {16'h0000, a});
		apb(1'b1, mdu_pkg::HR_OPB, {16'h0000, b});
		apb(1'b1, mdu_pkg::HR_CMD, {ad, 11'h000, 1'b1, 1'b0, op[2:0]});
	endtask
	// wait for done, compare result, flags and events, then clear the events
	task automatic fin(input logic [3:0] ist);
		do apb(1'b0, mdu_pkg::HR_ISTAT, 32'h0); while (rv[0] !== 1'b1);
		@(negedge pclk);
		chk("in_use", 0, riu);
		apb(1'b0, mdu_pkg::HR_RESULT, 32'h0);
		if (cop < 2 || !e[32]) chk("result", e[31:0], rv);
		apb(1'b0, mdu_pkg::HR_STATUS, 32'h0);
		chk("ovf", e[32], rv[16 + mdu_pkg::PSW_V_BIT]);
		apb(1'b0, mdu_pkg::HR_ISTAT, 32'h0);
		chk("istat", {ist[3:2], e[32], 1'b1}, rv[3:0]);
		apb(1'b1, mdu_pkg::HR_ISTAT, 32'h0000_000F);
		acc = e[31:0];
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		ce = 1'b1;
		acc = 32'h0000_0000;
		presetn = 1'b0;
		void'($urandom(32'h0B1F));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset state, then an unmapped place refused
		apb(1'b0, mdu_pkg::HR_STATUS, 32'h0);
		chk("status", 0, rv);
		apb(1'b0, mdu_pkg::HR_SAVE, 32'h0);
		chk("save", 0, rv);
		apb(1'b1, 8'h24, 32'hFFFF_FFFF);
		chk("wr_err", 1, re);
		apb(1'b0, 8'h24, 32'h0);
		chk("rd_err", 1, re);
		chk("rd_data", 0, rv);
		// every code back to back, zero divisors included
		for (int i = 0; i < 24; i++) begin
			go(i % 2, 16'($urandom), 16'($urandom), 16'h0100);
			fin(4'h0);
			go(i % 6, (i % 7 == 3) ? 16'h0000 : 16'($urandom), 16'($urandom), 16'h0104);
			fin(4'h0);
		end
		// level interrupt raised, masked, unmasked, then cleared
		apb(1'b1, mdu_pkg::HR_IMASK, 32'h1);
		go(1, 16'h8000, 16'h8000, 16'h0100);
		do apb(1'b0, mdu_pkg::HR_ISTAT, 32'h0); while (rv[0] !== 1'b1);
		for (int k = 0; k < 3; k++) begin
			@(negedge pclk);
			chk("irq", k != 1, irq);
			apb(1'b1, mdu_pkg::HR_IMASK, 32'(k != 0));
		end
		fin(4'h0);
		@(negedge pclk);
		chk("irq", 0, irq);
		// clock enable low: a register write is frozen out
		@(posedge pclk);
		ce <= 1'b0;
		apb(1'b1, mdu_pkg::HR_OPA, 32'h0000_5A5A);
		ce <= 1'b1;
		apb(1'b0, mdu_pkg::HR_OPA, 32'h0);
		chk("ce_hold", 32'h0000_8000, rv);
		// interrupt taken while idle returns to the address it carries
		apb(1'b1, mdu_pkg::HR_CMD, 32'h0300_0020);
		do apb(1'b0, mdu_pkg::HR_ISTAT, 32'h0); while (rv[2] !== 1'b1);
		apb(1'b0, mdu_pkg::HR_SAVE, 32'h0);
		chk("ret_idle", 32'h0300, rv[15:0]);
		apb(1'b1, mdu_pkg::HR_ISTAT, 32'h0000_000F);
		// multiply interrupted in its run; first left pending by a task switch, then resumed
		for (int k = 0; k < 2; k++) begin
			go(0, 16'($urandom), 16'($urandom), 16'h0200);
			apb(1'b1, mdu_pkg::HR_CMD, 32'h0000_0020);
			do apb(1'b0, mdu_pkg::HR_ISTAT, 32'h0); while (rv[2] !== 1'b1);
			@(negedge pclk);
			chk("in_use", 1, riu);
			apb(1'b0, mdu_pkg::HR_SAVE, 32'h0);
			chk("ret", 32'h0200, rv[15:0]);
			chk("resume", 1, rv[16 + mdu_pkg::MDC_ACT_BIT]);
			apb(1'b0, mdu_pkg::HR_STATUS, 32'h0);
			chk("pending", 1, rv[16 + mdu_pkg::PSW_INPROG_BIT]);
			if (k == 0)
				apb(1'b1, mdu_pkg::HR_TASK, 32'h0);
			apb(1'b1, mdu_pkg::HR_CMD, 32'h0000_0040);
			if (k == 1)
				fin(4'hC);
			else begin
				repeat (4) @(posedge pclk);
				apb(1'b0, mdu_pkg::HR_ISTAT, 32'h0);
				chk("no_refetch", 4'h4, rv[3:0]);
				apb(1'b1, mdu_pkg::HR_ISTAT, 32'h0000_000F);
			end
		end
		end_of_test();
	end
endmodule // testbench
